/* scd_divider.sv */
`timescale 1ns/100ps

// Function
// - Release with clock high: follow first rise
// - Release with clock low: follow second rise
// - Hold freezes dividers at next falling edge
// - Frozen dividers keep state except on master reset, never advance
// - Hold low unfreezes at next falling edge
// - Each rising edge advances chain when enabled
// - Master reset forces known zero state
module scd_divider
   import scd_pkg::*;
#(
   parameter int DIV_W = DIV_WIDTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire scd_pins_t pins,
   output scd_outs_t outs
);

   // -------------------------------------------------------------
   // Reset release and pin synchronisation
   // -------------------------------------------------------------
   logic rst_n;
   scd_pins_t pins_s;

   scd_sync #(.WIDTH(1)) u_rst_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(1'b1),
      .q(rst_n)
   );

   scd_sync #(.WIDTH(PIN_WIDTH)) u_pin_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d(pins),
      .q(pins_s)
   );

   // -------------------------------------------------------------
   // Edge detection on the synchronised source clock
   // -------------------------------------------------------------
   logic clk_prev;
   logic next_clk_prev;
   logic clk_rise;
   logic clk_fall;

   always_comb begin
      next_clk_prev = pins_s.src_clk;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= next_clk_prev;
      end
   end

   assign clk_rise = pins_s.src_clk & ~clk_prev;
   assign clk_fall = ~pins_s.src_clk & clk_prev;

   // -------------------------------------------------------------
   // Hold flop, updated on falling edges only
   // -------------------------------------------------------------
   logic frozen;
   logic next_frozen;

   always_comb begin
      next_frozen = frozen;
      if (clk_fall) begin
         next_frozen = pins_s.divider_hold;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frozen <= 1'b0;
      end else begin
         frozen <= next_frozen;
      end
   end

   // -------------------------------------------------------------
   // Reset recovery and divider counter
   // -------------------------------------------------------------
   scd_state_t state;
   scd_state_t next_state;
   logic [DIV_W-1:0] cnt;
   logic [DIV_W-1:0] next_cnt;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      if (pins_s.divider_sync_reset) begin
         next_state = ST_RESET;
         next_cnt = DIV_W'(CNT_RESET);
      end else begin
         unique case (state)
            ST_RESET: begin
               // Clock level at release picks first or second rise
               next_state = pins_s.src_clk ? ST_RUN : ST_SKIP;
            end
            ST_SKIP: begin
               if (clk_rise) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (clk_rise && !frozen) begin
                  next_cnt = cnt + DIV_W'(CNT_STEP);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RESET;
         cnt <= DIV_W'(CNT_RESET);
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // One counter feeds all taps so common edges coincide
   assign outs.half_rate_out = cnt[HALF_BIT];
   assign outs.quarter_rate_out = cnt[QUARTER_BIT];
   assign outs.eighth_rate_out = cnt[EIGHTH_BIT];

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   sequence s_release_high;
      state == ST_RESET && !pins_s.divider_sync_reset && pins_s.src_clk;
   endsequence

   sequence s_release_low;
      state == ST_RESET && !pins_s.divider_sync_reset && !pins_s.src_clk;
   endsequence

   sequence s_run_step;
      state == ST_RUN && clk_rise && !frozen && !pins_s.divider_sync_reset;
   endsequence

   property p_release_high;
      @(posedge clk) disable iff (!rst_n)
      s_release_high |=> state == ST_RUN;
   endproperty
   a_release_high: assert property (p_release_high)
      else $error("release with clock high did not enter run");

   property p_release_low;
      @(posedge clk) disable iff (!rst_n)
      s_release_low |=> state == ST_SKIP;
   endproperty
   a_release_low: assert property (p_release_low)
      else $error("release with clock low did not skip a rise");

   property p_skip_rise;
      @(posedge clk) disable iff (!rst_n)
      state == ST_SKIP && clk_rise && !pins_s.divider_sync_reset
         |=> state == ST_RUN && $stable(cnt);
   endproperty
   a_skip_rise: assert property (p_skip_rise)
      else $error("first rise after low release advanced counter");

   property p_freeze;
      @(posedge clk) disable iff (!rst_n)
      clk_fall && pins_s.divider_hold |=> frozen;
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("hold not taken at falling edge");

   property p_frozen_stable;
      @(posedge clk) disable iff (!rst_n)
      frozen && !pins_s.divider_sync_reset |=> cnt == $past(cnt);
   endproperty
   a_frozen_stable: assert property (p_frozen_stable)
      else $error("counter moved while frozen");

   property p_unfreeze;
      @(posedge clk) disable iff (!rst_n)
      frozen && clk_fall && !pins_s.divider_hold |=> !frozen;
   endproperty
   a_unfreeze: assert property (p_unfreeze)
      else $error("hold release not taken at falling edge");

   property p_advance;
      @(posedge clk) disable iff (!rst_n)
      s_run_step |=> cnt == $past(cnt) + DIV_W'(CNT_STEP);
   endproperty
   a_advance: assert property (p_advance)
      else $error("rising edge did not advance counter");

   property p_reset_zero;
      @(posedge clk) disable iff (!rst_n)
      pins_s.divider_sync_reset |=> cnt == DIV_W'(CNT_RESET) && state == ST_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("master reset did not clear dividers");

   property p_outs_reset;
      @(posedge clk) disable iff (!rst_n)
      pins_s.divider_sync_reset
         |=> !outs.half_rate_out && !outs.quarter_rate_out && !outs.eighth_rate_out;
   endproperty
   a_outs_reset: assert property (p_outs_reset)
      else $error("master reset left an output high");

   property p_half_toggle;
      @(posedge clk) disable iff (!rst_n)
      s_run_step |=> outs.half_rate_out != $past(outs.half_rate_out);
   endproperty
   a_half_toggle: assert property (p_half_toggle)
      else $error("half rate output missed a counted rise");

   property p_aligned;
      @(posedge clk) disable iff (!rst_n || pins_s.divider_sync_reset)
      $changed(outs.quarter_rate_out) && state == ST_RUN |-> $fell(outs.half_rate_out);
   endproperty
   a_aligned: assert property (p_aligned)
      else $error("quarter output moved without half falling");

endmodule : scd_divider

/* scd_pkg.sv */
package scd_pkg;

   // -------------------------------------------------------------
   // Widths and positions
   // -------------------------------------------------------------
   localparam int SYNC_STAGES = 2;
   localparam int DIV_WIDTH = 3;
   localparam int HALF_BIT = 0;
   localparam int QUARTER_BIT = 1;
   localparam int EIGHTH_BIT = 2;
   localparam logic [DIV_WIDTH-1:0] CNT_RESET = 3'h0;
   localparam logic [DIV_WIDTH-1:0] CNT_STEP = 3'h1;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef struct packed {
      logic src_clk;
      logic divider_hold;
      logic divider_sync_reset;
   } scd_pins_t;

   localparam int PIN_WIDTH = $bits(scd_pins_t);

   typedef struct packed {
      logic eighth_rate_out;
      logic quarter_rate_out;
      logic half_rate_out;
   } scd_outs_t;

   typedef enum logic [1:0] {
      ST_RESET,
      ST_SKIP,
      ST_RUN
   } scd_state_t;

endpackage : scd_pkg

/* scd_sync.sv */
`timescale 1ns/100ps

module scd_sync
   import scd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   // -------------------------------------------------------------
   // Two-stage synchroniser, stage one read only by stage two
   // -------------------------------------------------------------
   logic [WIDTH-1:0] stage [SYNC_STAGES];
   logic [WIDTH-1:0] next_stage [SYNC_STAGES];

   always_comb begin
      next_stage[0] = d;
      for (int i = 1; i < SYNC_STAGES; i++) begin
         next_stage[i] = stage[i-1];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            stage[i] <= next_stage[i];
         end
      end
   end

   assign q = stage[SYNC_STAGES-1];

endmodule : scd_sync

/* scd_src_model.sv */
`timescale 1ns/100ps

module scd_src_model
   import scd_pkg::*;
#(
   parameter int HALF_CLKS = 6
) (
   input wire logic clk,
   output scd_pins_t pins
);

   // -------------------------------------------------------------
   // Source clock and control, changed at falling clk edges only
   // -------------------------------------------------------------
   initial begin
      pins = '0;
   end

   task automatic flip_clk();
      pins.src_clk = ~pins.src_clk;
      repeat (HALF_CLKS) @(negedge clk);
   endtask : flip_clk

   task automatic set_ctl(input logic hold, input logic rst);
      pins.divider_hold = hold;
      pins.divider_sync_reset = rst;
      repeat (HALF_CLKS) @(negedge clk);
   endtask : set_ctl

endmodule : scd_src_model

/* tb_sync_clock_divider_2_4_8.sv */
`timescale 1ns/100ps

module tb_sync_clock_divider_2_4_8
   import scd_pkg::*;
;

   typedef struct {
      int n;
      scd_outs_t exp;
   } scd_row_t;

   logic clk;
   logic arst_n;
   scd_pins_t pins;
   scd_outs_t outs;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   scd_row_t rows[4] = '{'{1, 3'h2}, '{5, 3'h7}, '{1, 3'h0}, '{2, 3'h2}};

   scd_src_model i_src (.clk(clk), .pins(pins));
   scd_divider i_dut (.clk(clk), .arst_n(arst_n), .pins(pins), .outs(outs));

   // -------------------------------------------------------------
   // Clock, timeout and shared tasks
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input scd_outs_t exp);
      n_compared++;
      if (outs !== exp) begin
         mismatches++;
         $display("unexpected at %0t: outs %b expected %b", $time, outs, exp);
      end
   endtask : chk

   task automatic rises(input int n);
      repeat (2 * n) begin
         i_src.flip_clk();
      end
   endtask : rises

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(3'h0);
      i_src.set_ctl(1'b0, 1'b1);
      chk(3'h0);
      i_src.set_ctl(1'b0, 1'b0);
      i_src.flip_clk();
      chk(3'h0);
      i_src.flip_clk();
      i_src.flip_clk();
      chk(3'h1);
      foreach (rows[i]) begin
         rises(rows[i].n);
         chk(rows[i].exp);
      end
      i_src.set_ctl(1'b0, 1'b1);
      chk(3'h0);
      i_src.set_ctl(1'b0, 1'b0);
      rises(1);
      chk(3'h1);
      i_src.flip_clk();
      i_src.set_ctl(1'b1, 1'b0);
      i_src.flip_clk();
      chk(3'h2);
      rises(2);
      chk(3'h2);
      i_src.set_ctl(1'b0, 1'b0);
      rises(1);
      chk(3'h3);
      rises(1);
      chk(3'h4);
      // Asynchronous reset in mid-run, then master reset
      arst_n = 1'b0;
      @(negedge clk);
      chk(3'h0);
      arst_n = 1'b1;
      i_src.set_ctl(1'b0, 1'b1);
      i_src.set_ctl(1'b0, 1'b0);
      rises(1);
      chk(3'h1);
      tally_and_finish();
   end

endmodule : tb_sync_clock_divider_2_4_8
